// file: hw/irc_defines.vh
/*
  Constants for the infrared carrier generator: reset values, field widths and
  the transfer timing of the output-enable and high-width latches.
  Assumes inclusion by bare name from the design file.
*/
`ifndef IRC_DEFINES_VH
`define IRC_DEFINES_VH

// ****************************************
// Widths and reset values
// ****************************************
`define IRC_CNT_W        8
`define IRC_CNT_RST      8'h00
`define IRC_CMP_RST      8'h00

// ****************************************
// Timing counts in count clocks
// ****************************************
`define IRC_HW_XFER_CLKS 2'h3
`define IRC_OE_XFER_CLKS 2'h2

`endif

// file: hw/irc_carrier_gen.v
/*
  Infrared carrier generator: an 8-bit counter alternates between a low-width
  and a high-width compare, toggling a carrier clock; a gating event from an
  external event counter moves the master output-enable bit into the slave bit,
  which gates the carrier onto the output pin.
  Assumes ref_clk at 200 MHz, count_tick a single-cycle enable from the count
  clock prescaler on ref_clk, and event_counter_irq / high_width_compare from
  another clock domain (synchronised here).
*/
`timescale 1ns/1ps
`include "irc_defines.vh"

module irc_carrier_gen #(
  parameter CNT_W = `IRC_CNT_W
) (
  // Clock, reset, enable
  input  wire             ref_clk,
  input  wire             rstn,
  input  wire             clk_en,
  input  wire             count_tick,
  // Control bits
  input  wire             carrier_timer_enable,
  input  wire             event_counter_enable,
  input  wire             remote_output_enable,
  input  wire             output_enable_master,
  input  wire [CNT_W-1:0] low_width_compare,
  input  wire [CNT_W-1:0] high_width_compare,
  input  wire             high_width_write,
  // Event counter
  input  wire             event_counter_irq,
  // Status and outputs
  output reg              carrier_timer_irq,
  output reg              gating_transfer_event,
  output reg              output_enable_slave,
  output reg              carrier_clock,
  output reg              carrier_output_pin
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  reg             irq_meta_q;
  reg             irq_sync_q;
  reg             wr_meta_q;
  reg             wr_sync_q;
  reg             wr_prev_q;
  reg [CNT_W-1:0] hw_meta_q;
  reg [CNT_W-1:0] hw_sync_q;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_meta_q <= 1'b0;
      irq_sync_q <= 1'b0;
      wr_meta_q  <= 1'b0;
      wr_sync_q  <= 1'b0;
      wr_prev_q  <= 1'b0;
      hw_meta_q  <= `IRC_CMP_RST;
      hw_sync_q  <= `IRC_CMP_RST;
    end else if (clk_en) begin
      irq_meta_q <= event_counter_irq;
      irq_sync_q <= irq_meta_q;
      wr_meta_q  <= high_width_write;
      wr_sync_q  <= wr_meta_q;
      wr_prev_q  <= wr_sync_q;
      hw_meta_q  <= high_width_compare;
      hw_sync_q  <= hw_meta_q;
    end
  end

  wire wr_pulse = wr_sync_q & ~wr_prev_q;

  // ****************************************
  // Gating transfer event on count clock
  // ****************************************
  reg       irq_held_q;
  reg       gate_prev_q;
  reg [1:0] oe_cnt_q;
  reg       oe_pend_q;

  // Latch the irq until the next count clock so slow prescales do not miss it
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_held_q <= 1'b0;
    end else if (clk_en) begin
      if (irq_sync_q)
        irq_held_q <= 1'b1;
      else if (count_tick)
        irq_held_q <= 1'b0;
    end
  end

  // Event and its edge memory both step on count clocks only
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gating_transfer_event <= 1'b0;
      gate_prev_q           <= 1'b0;
    end else if (clk_en && count_tick) begin
      gating_transfer_event <= irq_held_q | irq_sync_q;
      gate_prev_q           <= gating_transfer_event;
    end
  end

  // ****************************************
  // Master to slave transfer
  // ****************************************
  wire gate_rise = gating_transfer_event & ~gate_prev_q;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      oe_cnt_q            <= 2'h0;
      oe_pend_q           <= 1'b0;
      output_enable_slave <= 1'b0;
    end else if (clk_en && count_tick) begin
      if (gate_rise) begin
        oe_pend_q <= 1'b1;
        oe_cnt_q  <= 2'h1;
      end else if (oe_pend_q) begin
        if (oe_cnt_q == `IRC_OE_XFER_CLKS) begin
          output_enable_slave <= output_enable_master;
          oe_pend_q           <= 1'b0;
        end else begin
          oe_cnt_q <= oe_cnt_q + 2'h1;
        end
      end
    end
  end

  // ****************************************
  // Counter, compare select and carrier clock
  // ****************************************
  reg [CNT_W-1:0] cnt_q;
  reg             sel_high_q;
  reg             first_q;
  reg [CNT_W-1:0] hw_active_q;
  reg [CNT_W-1:0] hw_latch_q;
  reg             hw_pend_q;
  reg [1:0]       hw_age_q;

  wire             run       = carrier_timer_enable;
  wire             step      = run && count_tick && !first_q;
  wire [CNT_W-1:0] cmp_value = sel_high_q ? hw_active_q : low_width_compare;
  wire             match     = (cnt_q == cmp_value);
  wire             hw_ready  = hw_pend_q && (hw_age_q == `IRC_HW_XFER_CLKS);
  wire             hw_take   = step && match && sel_high_q && hw_ready && !wr_pulse;

  // ****************************************
  // Start-up mask
  // ****************************************
  // One count clock is masked at start; carrier stays at default
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      first_q <= 1'b1;
    end else if (clk_en) begin
      if (!run)
        first_q <= 1'b1;
      else if (count_tick)
        first_q <= 1'b0;
    end
  end

  // ****************************************
  // Counter
  // ****************************************
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= `IRC_CNT_RST;
    end else if (clk_en) begin
      if (!run)
        cnt_q <= `IRC_CNT_RST;
      else if (step && match)
        cnt_q <= `IRC_CNT_RST;
      else if (step)
        cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // Compare select, carrier clock and irq
  // ****************************************
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sel_high_q    <= 1'b0;
      carrier_clock <= 1'b0;
    end else if (clk_en) begin
      if (!run) begin
        sel_high_q    <= 1'b0;
        carrier_clock <= 1'b0;
      end else if (step && match) begin
        sel_high_q    <= ~sel_high_q;
        carrier_clock <= ~carrier_clock;
      end
    end
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      carrier_timer_irq <= 1'b0;
    else if (clk_en)
      carrier_timer_irq <= step && match;
  end

  // ****************************************
  // High-width latch
  // ****************************************
  // New high width is held until it is old enough and the old value matches;
  // a write in the transfer cycle wins so the newest value is never lost
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hw_latch_q <= `IRC_CMP_RST;
      hw_pend_q  <= 1'b0;
      hw_age_q   <= 2'h0;
    end else if (clk_en) begin
      if (wr_pulse) begin
        hw_latch_q <= hw_sync_q;
        hw_pend_q  <= 1'b1;
        hw_age_q   <= 2'h0;
      end else if (hw_take) begin
        hw_pend_q <= 1'b0;
      end else if (count_tick && hw_pend_q && hw_age_q != `IRC_HW_XFER_CLKS) begin
        hw_age_q <= hw_age_q + 2'h1;
      end
    end
  end

  // ****************************************
  // Active high width
  // ****************************************
  // While stopped with no write pending the value is taken directly, as nothing is being compared
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      hw_active_q <= `IRC_CMP_RST;
    end else if (clk_en) begin
      if (!run && !hw_pend_q)
        hw_active_q <= hw_sync_q;
      else if (hw_take)
        hw_active_q <= hw_latch_q;
    end
  end

  // ****************************************
  // Output gating
  // ****************************************
  reg cc_prev_q;
  reg gate_on_q;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn)
      cc_prev_q <= 1'b0;
    else if (clk_en)
      cc_prev_q <= carrier_clock;
  end

  wire pin_allow = run && remote_output_enable;
  wire rise_cc   = carrier_clock && !cc_prev_q;

  // Gate opens only on a rising carrier edge, closes when carrier is low with the slave bit off or the pin is disallowed,
  // so a high pulse on the pin is cut short only by a stop or remote-off
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gate_on_q <= 1'b0;
    end else if (clk_en) begin
      if (!pin_allow)
        gate_on_q <= 1'b0;
      else if (output_enable_slave && rise_cc)
        gate_on_q <= 1'b1;
      else if (!output_enable_slave && !carrier_clock)
        gate_on_q <= 1'b0;
    end
  end

  // Pin trails the carrier by one clock so it comes straight from a flop
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      carrier_output_pin <= 1'b0;
    end else if (clk_en) begin
      if (!pin_allow)
        carrier_output_pin <= 1'b0;
      else
        carrier_output_pin <= (gate_on_q || (output_enable_slave && !cc_prev_q)) && carrier_clock;
    end
  end

  // Event counter enable is not used by any logic in this module
  wire unused_ok = event_counter_enable;

endmodule // irc_carrier_gen

// file: verif/irc_monitor.sv
/* Port checker for irc_carrier_gen. Assumes count_tick high every cycle. */
`timescale 1ns/1ps
module irc_monitor #(parameter CNT_W = 8) (
  input wire             ref_clk,
  input wire             rstn,
  input wire             carrier_timer_enable,
  input wire             remote_output_enable,
  input wire             output_enable_master,
  input wire [CNT_W-1:0] low_width_compare,
  input wire             event_counter_irq,
  input wire             carrier_timer_irq,
  input wire             gating_transfer_event,
  input wire             output_enable_slave,
  input wire             carrier_clock,
  input wire             carrier_output_pin
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  reg [CNT_W:0] run_q;
  reg           seen_q;
  // First low phase holds the masked tick, so it is skipped
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      run_q  <= 1;
      seen_q <= 1'b0;
    end else begin
      run_q  <= $changed(carrier_clock) ? 1 : run_q + 1'b1;
      seen_q <= carrier_timer_enable && (seen_q || $fell(carrier_clock));
    end
  end
  a_low_width: assert property ($rose(carrier_clock) && seen_q |->
    run_q == {1'b0, low_width_compare} + 1'b1) else $error("low width");
  a_irq_toggle: assert property (carrier_timer_enable |->
    carrier_timer_irq == $changed(carrier_clock)) else $error("irq");
  a_stop_idle: assert property (!carrier_timer_enable [*2] |->
    !carrier_clock && !carrier_output_pin) else $error("stop");
  a_remote_off: assert property (!remote_output_enable [*2] |-> !carrier_output_pin)
    else $error("remote");
  a_pin_start: assert property ($rose(carrier_output_pin) |->
    $past(carrier_clock) && !$past(carrier_clock, 2)) else $error("start");
  a_pin_hold: assert property ($fell(carrier_output_pin) && remote_output_enable &&
    carrier_timer_enable |-> !$past(carrier_clock)) else $error("hold");
  a_slave_copy: assert property ($rose(gating_transfer_event) |->
    ##[1:3] output_enable_slave == output_enable_master) else $error("copy");
  a_gate_sync: assert property ($rose(event_counter_irq) |-> ##[1:5] gating_transfer_event)
    else $error("sync");
endmodule // irc_monitor
bind irc_carrier_gen irc_monitor #(.CNT_W(CNT_W)) i_irc_monitor (.ref_clk(ref_clk), .rstn(rstn),
  .carrier_timer_enable(carrier_timer_enable), .remote_output_enable(remote_output_enable),
  .output_enable_master(output_enable_master), .low_width_compare(low_width_compare),
  .event_counter_irq(event_counter_irq), .carrier_timer_irq(carrier_timer_irq),
  .gating_transfer_event(gating_transfer_event), .output_enable_slave(output_enable_slave),
  .carrier_clock(carrier_clock), .carrier_output_pin(carrier_output_pin));

// file: verif/irc_ir_receiver.sv
/* Infrared receiver model: measures each high pulse on the pin in clocks. */
`timescale 1ns/1ps
module irc_ir_receiver (
  input  wire       ref_clk,
  input  wire       rstn,
  input  wire       carrier_output_pin,
  output reg        pulse_done,
  output reg  [9:0] pulse_len
);
  reg [9:0] len_q;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      len_q      <= 10'h000;
      pulse_done <= 1'b0;
      pulse_len  <= 10'h000;
    end else begin
      len_q      <= carrier_output_pin ? len_q + 1'b1 : 10'h000;
      pulse_done <= !carrier_output_pin && len_q != 10'h000;
      pulse_len  <= len_q;
    end
  end
endmodule // irc_ir_receiver

// file: verif/testbench.sv
/* Self-checking bench for irc_carrier_gen. Count tick runs every clock. */
`timescale 1ns/1ps
module testbench;
  reg        ref_clk = 0, rstn = 0, ena = 0, remote = 0, master = 0, hw_wr = 0, ev_irq = 0;
  reg  [7:0] low_cmp = 8'h04, high_cmp = 8'h00;
  wire       slave, cclk, pin, done;
  wire [9:0] len;
  int        err_count = 0, check_count = 0;
  int        exp_q[$];
  always #2.5 ref_clk = ~ref_clk;
  irc_carrier_gen i_irc_carrier_gen (.ref_clk(ref_clk), .rstn(rstn), .clk_en(1'b1), .count_tick(1'b1),
    .carrier_timer_enable(ena), .event_counter_enable(1'b0), .remote_output_enable(remote),
    .output_enable_master(master), .low_width_compare(low_cmp), .high_width_compare(high_cmp),
    .high_width_write(hw_wr), .event_counter_irq(ev_irq), .carrier_timer_irq(), .gating_transfer_event(),
    .output_enable_slave(slave), .carrier_clock(cclk), .carrier_output_pin(pin));
  irc_ir_receiver i_irc_ir_receiver (.ref_clk(ref_clk), .rstn(rstn), .carrier_output_pin(pin),
    .pulse_done(done), .pulse_len(len));
  task automatic check_val(input string name, input logic [9:0] e, input logic [9:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", name, e, g);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  always @(negedge ref_clk) if (done && exp_q.size() > 0) check_val("high", exp_q.pop_front(), len);
  // Master is rewritten well clear of each gating event
  task automatic gate(input logic m);
    master = m;
    cyc(5);
    ev_irq = 1;
    cyc(1);
    ev_irq = 0;
    cyc(10);
    check_val("slave", {9'h000, m}, {9'h000, slave});
  endtask
  // Old width may run one more period if the write lands near a match
  task automatic set_high(input logic [7:0] m);
    int old;
    old = high_cmp;
    high_cmp = m;
    hw_wr = 1;
    cyc(2);
    hw_wr = 0;
    cyc(2 * (low_cmp + old) + 12);
    repeat (4) exp_q.push_back(m + 1);
    while (exp_q.size() > 0) cyc(1);
  endtask
  initial begin
    void'($urandom(32'h68beac02));
    cyc(4);
    rstn = 1;
    low_cmp = 8'h04 + 8'($urandom % 8);
    remote = 1;
    cyc(2);
    ena = 1;
    gate(1);
    set_high(low_cmp + 8'($urandom % 9) + 8'h01);
    set_high(8'($urandom % 4));
    set_high(low_cmp);
    gate(0);
    cyc(2 * low_cmp + 40);
    check_val("pin off", 10'h000, {9'h000, pin});
    gate(1);
    remote = 0;
    cyc(3);
    check_val("remote", 10'h000, {9'h000, pin});
    remote = 1;
    ena = 0;
    cyc(3);
    check_val("stopped", 10'h000, {8'h00, cclk, pin});
    ena = 1;
    cyc(100);
    rstn = 0;
    cyc(2);
    check_val("reset", 10'h000, {8'h00, slave, pin});
    stop_test;
  end
  initial begin
    cyc(60000);
    err_count++;
    stop_test;
  end
endmodule // testbench
